// File: hw/ncmg_gate.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01: error reset honoured per scope select
// R02: full network reset only in network mode
// R03: terminal, power, keypad resets always accepted
// R04: network resets refused during line fault
// R05: reset in network mode goes external
// R06: link silent about one second during reset
// R07: cyclic refresh between stated interval bounds; the gate does not check the refresh interval
// R08: network control only in network mode
// R09: monitoring serviced in every mode
// R10: parameter reads serviced in every mode
// R11: monitor values reported in fixed units
// R12: special monitor chosen by selector code
// R13: status always; others after code written
// R14: status word carries eight drive flags
// R15: programmed mode widens network parameter writes; the gate instead refuses them unless param_ext_writable
// R16: parameter write while running is error
// R17: refused commands change no state
module ncmg_gate #(
  parameter int SILENCE_CYC = ncmg_pkg::NCMG_SILENCE_CYC
) (
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     req_valid,
  input  wire ncmg_pkg::ncmg_req_t      req,
  input  wire logic                     mode_switch_valid,
  input  wire ncmg_pkg::ncmg_mode_t     mode_switch,
  input  wire logic                     reset_scope_select,
  input  wire logic [7:0]               link_startup_mode_select,
  input  wire logic                     programmed_mode,
  input  wire logic                     param_ext_writable,
  input  wire logic                     line_fault_pin,
  input  wire logic                     hw_reset_terminal,
  input  wire logic                     local_keypad_reset,
  input  wire logic                     local_keypad_err_reset,
  input  wire logic                     term_run_req,
  input  wire ncmg_pkg::ncmg_status_t   drive_status,
  input  wire ncmg_pkg::ncmg_monitor_t  drive_monitor,
  input  wire logic [15:0][15:0]        special_items,
  output ncmg_pkg::ncmg_mode_t          mode_reg,
  output logic                          full_reset_reg,
  output logic                          err_reset_reg,
  output logic                          run_cmd_reg,
  output logic                          freq_set_reg,
  output logic                          stop_cmd_reg,
  output logic                          param_write_reg,
  output logic                          param_read_reg,
  output logic                          write_error_reg,
  output logic                          refused_reg,
  output logic                          term_run_ok_reg,
  output logic [15:0]                   cmd_data_reg,
  output logic                          link_silent_reg,
  output logic [7:0]                    status_word_reg,
  output logic [15:0]                   monitor_word_reg,
  output logic [15:0]                   special_word
);
  // line fault comes from the link pins: two-flop synchroniser
  logic fault_meta_reg;
  logic fault_sync_reg;
  logic hwres_meta_reg;
  logic hwres_sync_reg;
  logic [7:0] mon_sel_reg;              // last monitor code written
  logic [3:0] special_sel_reg;          // special monitor selector
  logic [$clog2(SILENCE_CYC+1)-1:0] silence_cnt_reg;

  // decoded acceptance for the present command
  logic is_net;
  logic is_reset_kind;
  logic accept;
  logic any_reset;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_meta_reg <= 1'b0;
      fault_sync_reg <= 1'b0;
      hwres_meta_reg <= 1'b0;
      hwres_sync_reg <= 1'b0;
    end else begin
      fault_meta_reg <= line_fault_pin;
      fault_sync_reg <= fault_meta_reg;
      hwres_meta_reg <= hw_reset_terminal;
      hwres_sync_reg <= hwres_meta_reg;
    end
  end

  // acceptance decision, taken against current mode and fault (R17)
  always_comb begin
    is_net = (mode_reg == ncmg_pkg::NCMG_MODE_NETWORK);
    is_reset_kind = (req.kind == ncmg_pkg::NCMG_CMD_FULL_RESET) ||
                    (req.kind == ncmg_pkg::NCMG_CMD_ERR_RESET);
    accept = 1'b0;
    case (req.kind)
      // R02: full reset network only
      ncmg_pkg::NCMG_CMD_FULL_RESET: accept = is_net;
      // R01: scope select gates error reset
      ncmg_pkg::NCMG_CMD_ERR_RESET:  accept = !reset_scope_select || is_net;
      // R08: control needs network mode
      ncmg_pkg::NCMG_CMD_RUN,
      ncmg_pkg::NCMG_CMD_FREQ,
      ncmg_pkg::NCMG_CMD_STOP:       accept = is_net;
      // R15: programmed mode uses external writability
      ncmg_pkg::NCMG_CMD_PARAM_WRITE:
        accept = is_net && (!programmed_mode || param_ext_writable);
      // R09: monitoring serviced in every mode
      ncmg_pkg::NCMG_CMD_MONITOR,
      ncmg_pkg::NCMG_CMD_SPECIAL_SEL: accept = 1'b1;
      // R10: parameter reads serviced in every mode
      ncmg_pkg::NCMG_CMD_PARAM_READ: accept = 1'b1;
      default:                       accept = 1'b0;
    endcase
    // R04: no network reset during fault
    if (is_reset_kind && fault_sync_reg) begin
      accept = 1'b0;
    end
    // no commands heard while the link is silent
    if (link_silent_reg) begin
      accept = 1'b0;
    end
  end

  // R03: local resets accepted any mode
  assign any_reset = hwres_sync_reg || local_keypad_reset || local_keypad_err_reset ||
                     (req_valid && accept && is_reset_kind);

  // accepted commands answered by their strobe, refused ones by refused_reg; monitor and selector raise none
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      full_reset_reg  <= 1'b0;
      err_reset_reg   <= 1'b0;
      run_cmd_reg     <= 1'b0;
      freq_set_reg    <= 1'b0;
      stop_cmd_reg    <= 1'b0;
      param_write_reg <= 1'b0;
      param_read_reg  <= 1'b0;
      write_error_reg <= 1'b0;
      refused_reg     <= 1'b0;
    end else begin
      full_reset_reg  <= hwres_sync_reg || local_keypad_reset ||
                         (req_valid && accept && req.kind == ncmg_pkg::NCMG_CMD_FULL_RESET);
      err_reset_reg   <= local_keypad_err_reset ||
                         (req_valid && accept && req.kind == ncmg_pkg::NCMG_CMD_ERR_RESET);
      run_cmd_reg     <= req_valid && accept && req.kind == ncmg_pkg::NCMG_CMD_RUN;
      freq_set_reg    <= req_valid && accept && req.kind == ncmg_pkg::NCMG_CMD_FREQ;
      stop_cmd_reg    <= req_valid && accept && req.kind == ncmg_pkg::NCMG_CMD_STOP;
      param_read_reg  <= req_valid && accept && req.kind == ncmg_pkg::NCMG_CMD_PARAM_READ;
      // R16: write while running flagged
      param_write_reg <= req_valid && accept && !drive_status.running &&
                         req.kind == ncmg_pkg::NCMG_CMD_PARAM_WRITE;
      write_error_reg <= req_valid && accept && drive_status.running &&
                         req.kind == ncmg_pkg::NCMG_CMD_PARAM_WRITE;
      refused_reg     <= req_valid && !accept;
    end
  end

  // data that rides with an accepted command; refused ones and rejected writes leave it alone
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_data_reg <= ncmg_pkg::NCMG_WORD_RST;
    end else if (req_valid && accept && !(drive_status.running &&
                 req.kind == ncmg_pkg::NCMG_CMD_PARAM_WRITE)) begin
      cmd_data_reg <= req.data;
    end
  end

  // R08: terminal run refused in keypad
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      term_run_ok_reg <= 1'b0;
    end else begin
      term_run_ok_reg <= term_run_req && (mode_reg != ncmg_pkg::NCMG_MODE_KEYPAD);
    end
  end

  // operation mode; starts external, reset moves network to external
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= ncmg_pkg::NCMG_MODE_EXTERNAL;
    end else if (any_reset && mode_reg == ncmg_pkg::NCMG_MODE_NETWORK) begin
      // R05: reset drops to external
      mode_reg <= ncmg_pkg::NCMG_MODE_EXTERNAL;
    end else if (link_silent_reg && silence_cnt_reg == 1 &&
                 mode_reg == ncmg_pkg::NCMG_MODE_EXTERNAL &&
                 (link_startup_mode_select == ncmg_pkg::NCMG_STARTUP_NET_A ||
                  link_startup_mode_select == ncmg_pkg::NCMG_STARTUP_NET_B ||
                  link_startup_mode_select == ncmg_pkg::NCMG_STARTUP_NET_C)) begin
      // R05: startup code restores network
      mode_reg <= ncmg_pkg::NCMG_MODE_NETWORK;
    end else if (mode_switch_valid) begin
      mode_reg <= mode_switch;
    end
  end

  // R06: silence link for one second
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      silence_cnt_reg <= '0;
      link_silent_reg <= 1'b0;
    end else if (any_reset && full_reset_kind()) begin
      silence_cnt_reg <= ($bits(silence_cnt_reg))'(SILENCE_CYC);
      link_silent_reg <= 1'b1;
    end else if (silence_cnt_reg != 0) begin
      silence_cnt_reg <= silence_cnt_reg - 1'b1;
      link_silent_reg <= (silence_cnt_reg != 1);
    end
  end

  // only full resets silence the link, error resets do not
  function automatic logic full_reset_kind();
    full_reset_kind = hwres_sync_reg || local_keypad_reset ||
                      (req_valid && accept && req.kind == ncmg_pkg::NCMG_CMD_FULL_RESET);
  endfunction

  // R13: monitor code latched from master
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mon_sel_reg     <= ncmg_pkg::NCMG_MON_SEL_RST;
      special_sel_reg <= ncmg_pkg::NCMG_SPECIAL_RST;
    end else if (req_valid && accept) begin
      if (req.kind == ncmg_pkg::NCMG_CMD_MONITOR) begin
        mon_sel_reg <= req.code;
      end else if (req.kind == ncmg_pkg::NCMG_CMD_SPECIAL_SEL) begin
        // R12: selector picks special item
        special_sel_reg <= req.data[3:0];
      end
    end
  end

  // R14: status word always current
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_word_reg <= 8'h00;
    end else begin
      status_word_reg <= drive_status;
    end
  end

  // R11: scaled values by code
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      monitor_word_reg <= ncmg_pkg::NCMG_WORD_RST;
    end else if (mon_sel_reg == ncmg_pkg::NCMG_MON_FREQ) begin
      monitor_word_reg <= drive_monitor.freq_0p01hz;
    end else if (mon_sel_reg == ncmg_pkg::NCMG_MON_CURRENT) begin
      monitor_word_reg <= drive_monitor.current_0p01a;
    end else if (mon_sel_reg == ncmg_pkg::NCMG_MON_VOLTAGE) begin
      monitor_word_reg <= drive_monitor.voltage_0p1v;
    end else if (mon_sel_reg == ncmg_pkg::NCMG_MON_ALARM) begin
      monitor_word_reg <= drive_monitor.alarm_code;
    end else begin
      monitor_word_reg <= ncmg_pkg::NCMG_WORD_RST;
    end
  end

  // special monitor lookup, registered inside
  ncmg_special_mux #(
    .N_ITEMS (16)
  ) u_special (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .sel       (special_sel_reg),
    .items     (special_items),
    .value_reg (special_word)
  );

  // R02: network full reset command never taken outside network mode
  a_full_reset_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R02
    (req_valid && req.kind == ncmg_pkg::NCMG_CMD_FULL_RESET && !is_net && !hwres_sync_reg
     && !local_keypad_reset) |=> !full_reset_reg)
    else $error("full reset taken outside network mode");
  a_err_reset_scope: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R01
    (req_valid && req.kind == ncmg_pkg::NCMG_CMD_ERR_RESET && reset_scope_select
     && !is_net && !local_keypad_err_reset) |=> !err_reset_reg)
    else $error("error reset honoured out of scope");
  a_fault_blocks_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R04
    (req_valid && is_reset_kind && fault_sync_reg) |=> refused_reg)
    else $error("network reset taken during line fault");
  a_reset_to_ext: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R05
    (any_reset && is_net) |=> mode_reg == ncmg_pkg::NCMG_MODE_EXTERNAL)
    else $error("reset in network mode did not go external");
  a_silence_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R06
    $rose(link_silent_reg) |-> link_silent_reg[*8])
    else $error("link silence ended too soon");
  a_ctrl_net_only: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R08
    (req_valid && req.kind == ncmg_pkg::NCMG_CMD_RUN && !is_net) |=> !run_cmd_reg)
    else $error("run taken outside network mode");
  a_read_always: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R10
    (req_valid && req.kind == ncmg_pkg::NCMG_CMD_PARAM_READ && !link_silent_reg)
    |=> param_read_reg)
    else $error("parameter read not serviced");
  a_write_err_run: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R16
    param_write_reg |-> !$past(drive_status.running))
    else $error("parameter write while running");
  a_keypad_term: assert property (@(posedge ref_clk) disable iff (!reset_n)  // R08
    (mode_reg == ncmg_pkg::NCMG_MODE_KEYPAD) |=> !term_run_ok_reg)
    else $error("terminal run accepted in keypad mode");
endmodule
`default_nettype wire

// File: common/ncmg_pkg.sv
package ncmg_pkg;
  // operation modes of the drive
  typedef enum logic [1:0] {
    NCMG_MODE_NETWORK,
    NCMG_MODE_EXTERNAL,
    NCMG_MODE_KEYPAD
  } ncmg_mode_t;

  // network command kinds
  typedef enum logic [3:0] {
    NCMG_CMD_RUN,
    NCMG_CMD_FREQ,
    NCMG_CMD_STOP,
    NCMG_CMD_FULL_RESET,
    NCMG_CMD_ERR_RESET,
    NCMG_CMD_PARAM_WRITE,
    NCMG_CMD_PARAM_READ,
    NCMG_CMD_MONITOR,
    NCMG_CMD_SPECIAL_SEL
  } ncmg_cmd_t;

  // monitor code numbers written by the master
  localparam logic [7:0] NCMG_MON_NONE    = 8'h00;
  localparam logic [7:0] NCMG_MON_FREQ    = 8'h01;
  localparam logic [7:0] NCMG_MON_CURRENT = 8'h02;
  localparam logic [7:0] NCMG_MON_VOLTAGE = 8'h03;
  localparam logic [7:0] NCMG_MON_ALARM   = 8'h04;
  localparam logic [7:0] NCMG_MON_SPECIAL = 8'h05;
  localparam logic [7:0] NCMG_SPECIAL_SEL_CODE = 8'hF3;

  // link startup codes that bring network mode back after a full reset
  localparam logic [7:0] NCMG_STARTUP_NET_A = 8'h0A;  // 10
  localparam logic [7:0] NCMG_STARTUP_NET_B = 8'h0C;  // 12
  localparam logic [7:0] NCMG_STARTUP_NET_C = 8'h16;  // 22

  // reset values
  localparam logic [7:0]  NCMG_MON_SEL_RST   = 8'h00;
  localparam logic [3:0]  NCMG_SPECIAL_RST   = 4'h0;
  localparam logic [15:0] NCMG_WORD_RST      = 16'h0000;

  // timing: link silence during a drive reset
  localparam int NCMG_CLK_HZ        = 10000000;
  localparam int NCMG_SILENCE_MS    = 1000;
  localparam int NCMG_SILENCE_CYC   = NCMG_CLK_HZ / 1000 * NCMG_SILENCE_MS;
  // cyclic refresh bounds, in microseconds
  localparam int NCMG_REFRESH_MIN_US = 1100;
  localparam int NCMG_REFRESH_MAX_US = 141000;
  localparam int NCMG_REFRESH_MIN_CYC = (NCMG_CLK_HZ / 1000000) * NCMG_REFRESH_MIN_US;
  localparam int NCMG_REFRESH_MAX_CYC = (NCMG_CLK_HZ / 1000000) * NCMG_REFRESH_MAX_US;

  // one command from the master
  typedef struct packed {
    ncmg_cmd_t   kind;
    logic [7:0]  code;   // monitor code; special selector rides in data
    logic [15:0] data;   // frequency, parameter value
  } ncmg_req_t;

  // drive status flags, bit order of the status word
  typedef struct packed {
    logic alarm_output_flag;
    logic frequency_detect_flag;
    logic power_fail_flag;
    logic overload_flag;
    logic at_frequency_flag;
    logic reverse;
    logic forward;
    logic running;
  } ncmg_status_t;

  // scaled monitor quantities from the control core
  typedef struct packed {
    logic [15:0] freq_0p01hz;
    logic [15:0] current_0p01a;
    logic [15:0] voltage_0p1v;
    logic [15:0] alarm_code;
  } ncmg_monitor_t;
endpackage

// File: hw/ncmg_special_mux.sv
`timescale 1ns/1ps
`default_nettype none
// registered lookup of the special monitor quantity chosen by the master
module ncmg_special_mux #(
  parameter int N_ITEMS = 16
) (
  input  wire logic                               ref_clk,
  input  wire logic                               reset_n,
  input  wire logic [$clog2(N_ITEMS)-1:0]          sel,
  input  wire logic [N_ITEMS-1:0][15:0]            items,
  output logic      [15:0]                         value_reg
);
  // registered read so the top sees a flop output
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      value_reg <= ncmg_pkg::NCMG_WORD_RST;
    end else begin
      value_reg <= items[sel];
    end
  end
endmodule
`default_nettype wire

// File: verif/ncmg_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// fieldbus master: offers one command at a time from the plc program
module ncmg_master_model (
  input  wire logic                ref_clk,
  output var  ncmg_pkg::ncmg_req_t req,
  output var  logic                req_valid
);
  // idle link: nothing offered
  initial begin
    req_valid = 1'h0;
    req       = '0;
  end

  // one command per refresh slot
  // the payload is inverted once released, so a gate that samples it
  // outside valid sees garbage rather than a stale copy
  task automatic issue(input int k, input logic [15:0] d);
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req       <= {4'(k), d[7:0], d};
    @(posedge ref_clk);
    req_valid <= 1'h0;
    req       <= ~req;
  endtask
endmodule
`default_nettype wire

// File: verif/ncmg_gate_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// kinds go by ordinal: run 0, freq 1, stop 2, full reset 3, error reset 4,
// write 5, read 6, monitor 7, special select 8; modes: network 0,
// external 1, keypad 2
module ncmg_gate_tb_top;
  localparam int SIL = 20;  // short silence keeps the run brief
  // answer pulses, one bit each in the captured vector
  localparam logic [8:0] E_FULL = 9'h100;
  localparam logic [8:0] E_ERR  = 9'h080;
  localparam logic [8:0] E_RUN  = 9'h040;
  localparam logic [8:0] E_PW   = 9'h008;
  localparam logic [8:0] E_PR   = 9'h004;
  localparam logic [8:0] E_WERR = 9'h002;
  localparam logic [8:0] E_REF  = 9'h001;
  // gate inputs
  logic ref_clk, reset_n, req_valid, mode_switch_valid, reset_scope_select;
  logic programmed_mode, param_ext_writable, line_fault_pin, hw_reset_terminal;
  logic local_keypad_reset, local_keypad_err_reset, term_run_req;
  logic [7:0]              link_startup_mode_select;
  logic [15:0][15:0]       special_items;
  ncmg_pkg::ncmg_req_t     req;
  ncmg_pkg::ncmg_mode_t    mode_switch;
  ncmg_pkg::ncmg_status_t  drive_status;
  ncmg_pkg::ncmg_monitor_t drive_monitor;
  // gate outputs
  ncmg_pkg::ncmg_mode_t    mode_reg;
  logic full_reset_reg, err_reset_reg, run_cmd_reg, freq_set_reg, stop_cmd_reg;
  logic param_write_reg, param_read_reg, write_error_reg, refused_reg;
  logic term_run_ok_reg, link_silent_reg;
  logic [15:0]             cmd_data_reg;
  logic [7:0]              status_word_reg;
  logic [15:0]             monitor_word_reg;
  logic [15:0]             special_word;
  logic [8:0]              strobes;  // all answer pulses side by side
  int                      mismatches;
  int                      total_checks;

  assign strobes = {full_reset_reg, err_reset_reg, run_cmd_reg, freq_set_reg,
                    stop_cmd_reg, param_write_reg, param_read_reg,
                    write_error_reg, refused_reg};

  ncmg_master_model master_u (.ref_clk, .req, .req_valid);

  ncmg_gate #(.SILENCE_CYC(SIL)) dut_u (
    .ref_clk, .reset_n, .req_valid, .req, .mode_switch_valid, .mode_switch,
    .reset_scope_select, .link_startup_mode_select, .programmed_mode,
    .param_ext_writable, .line_fault_pin, .hw_reset_terminal,
    .local_keypad_reset, .local_keypad_err_reset, .term_run_req,
    .drive_status, .drive_monitor, .special_items, .mode_reg,
    .full_reset_reg, .err_reset_reg, .run_cmd_reg, .freq_set_reg,
    .stop_cmd_reg, .param_write_reg, .param_read_reg, .write_error_reg,
    .refused_reg, .term_run_ok_reg, .cmd_data_reg, .link_silent_reg,
    .status_word_reg, .monitor_word_reg, .special_word
  );

  // 10 MHz system clock
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // case inequality, so an unknown never passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // gathers any pulse in the two cycles after the taking edge, so either
  // registering latency the gate picks is judged alike
  task automatic cmd(input int k, input logic [15:0] d, input logic [8:0] exp);
    logic [8:0] got;
    master_u.issue(k, d);
    #1 got = strobes;
    @(posedge ref_clk);
    #1 got = got | strobes;
    chk(16'(got), 16'(exp), "answer");
  endtask

  task automatic set_mode(input int m);
    @(posedge ref_clk);
    mode_switch_valid <= 1'h1;
    mode_switch       <= ncmg_pkg::ncmg_mode_t'(m);
    @(posedge ref_clk);
    mode_switch_valid <= 1'h0;
    repeat (2) @(posedge ref_clk);
    #1 chk(16'(mode_reg), 16'(m), "mode");
  endtask

  // bounded wait for the link to speak again; n counts the cycles
  task automatic wait_quiet(output int n);
    n = 0;
    while (link_silent_reg !== 1'h0) begin
      @(posedge ref_clk);
      #1 n++;
      if (n > 200) begin
        mismatches++;
        $display("unexpected at %0t: link stays silent", $time);
        conclude();
      end
    end
  endtask

  // monitor and read across every mode, status checked once
  task automatic t_monitor();
    logic [15:0] want [4];
    want = '{16'h1234, 16'h0567, 16'h0890, 16'h00AB};
    #1 chk(monitor_word_reg, 16'h0000, "monitor idle");  // no code yet
    chk(16'(status_word_reg), 16'h00A4, "status");  // flag order
    for (int c = 1; c <= 4; c++) begin
      set_mode(c % 3);
      cmd(6, 16'h0030, E_PR);  // read served
      cmd(7, 16'(c), 9'h000);  // monitor served
      repeat (2) @(posedge ref_clk);
      #1 chk(monitor_word_reg, want[c-1], "monitor");  // scaled value
    end
    for (int s = 5; s <= 15; s += 10) begin
      cmd(8, 16'(s), 9'h000);  // selector
      repeat (2) @(posedge ref_clk);
      #1 chk(special_word, special_items[s], "special");  // selected item
    end
  endtask

  // refused commands leave the held data alone
  task automatic t_gate();
    logic [15:0] keep;
    keep = 16'h000F;  // data of the last selector command
    for (int m = 0; m < 3; m++) begin
      set_mode(m);
      #1 chk(16'(term_run_ok_reg), 16'(m != 2), "terminal run");  // terminal
      if (m == 0) begin
        term_run_req <= 1'h0;
        repeat (2) @(posedge ref_clk);
        #1 chk(16'(term_run_ok_reg), 16'h0000, "terminal idle");  // no request
        term_run_req <= 1'h1;
      end
      for (int k = 0; k < 3; k++) begin
        cmd(k, 16'h0100 + 16'(m * 4 + k), m == 0 ? E_RUN >> k : E_REF);  // gate
        if (m == 0) keep = 16'h0100 + 16'(k);
        chk(cmd_data_reg, keep, "held data");  // unchanged unless accepted
      end
      if (m != 0) cmd(3, 16'h0000, E_REF);  // full reset off network
    end
  endtask

  task automatic t_err();
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      reset_scope_select <= s[0];
      for (int m = 0; m < 3; m++) begin
        set_mode(m);
        cmd(4, 16'h0000, (s == 0 || m == 0) ? E_ERR : E_REF);  // scope
      end
    end
    reset_scope_select <= 1'h0;
  endtask

  // the last code is outside the restore list and must stay external
  task automatic t_full();
    logic [7:0] codes [4];
    int n;
    codes = '{8'h0A, 8'h0C, 8'h16, 8'h00};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      link_startup_mode_select <= codes[i];
      set_mode(0);
      cmd(3, 16'h0000, E_FULL);  // accepted
      chk(16'(mode_reg), 16'h0001, "mode after reset");  // external
      chk(16'(link_silent_reg), 16'h0001, "silent");  // silenced
      cmd(6, 16'h0000, E_REF);  // nothing served
      wait_quiet(n);
      chk(16'(n >= SIL - 6 && n <= SIL - 2), 16'h0001, "silence length");  // span
      @(posedge ref_clk);
      #1 chk(16'(mode_reg), 16'(i == 3), "mode restore");  // startup code
    end
  endtask

  task automatic t_fault();
    @(posedge ref_clk);
    line_fault_pin <= 1'h1;
    set_mode(0);
    cmd(3, 16'h0000, E_REF);  // full reset
    cmd(4, 16'h0000, E_REF);  // error reset
    chk(16'(mode_reg), 16'h0000, "mode kept");  // no change
    @(posedge ref_clk);
    line_fault_pin <= 1'h0;
    repeat (3) @(posedge ref_clk);
  endtask

  // terminal and keypad resets, taken in keypad mode
  task automatic t_local();
    logic [8:0] seen;
    int n;
    for (int p = 0; p < 3; p++) begin
      set_mode(2);
      @(posedge ref_clk);
      hw_reset_terminal      <= (p == 0);
      local_keypad_reset     <= (p == 1);
      local_keypad_err_reset <= (p == 2);
      @(posedge ref_clk);
      {hw_reset_terminal, local_keypad_reset, local_keypad_err_reset} <= 3'h0;
      #1 seen = strobes;
      repeat (5) begin
        @(posedge ref_clk);
        #1 seen = seen | strobes;
      end
      chk(16'(seen), 16'(p == 2 ? E_ERR : E_FULL), "local reset");  // accepted in keypad mode
      wait_quiet(n);
    end
  endtask

  task automatic t_write();
    set_mode(0);
    @(posedge ref_clk);
    drive_status <= 8'hA5;
    cmd(5, 16'h2222, E_WERR);  // running
    chk(cmd_data_reg, 16'h0000, "rejected write data");  // data kept
    drive_status <= 8'hA4;
    cmd(5, 16'h3333, E_PW);  // stopped
    chk(cmd_data_reg, 16'h3333, "write data");  // data passed
    programmed_mode <= 1'h1;
    cmd(5, 16'h4444, E_REF);  // not writable externally
    param_ext_writable <= 1'h1;
    cmd(5, 16'h5555, E_PW);  // writable externally
    programmed_mode <= 1'h0;
  endtask

  // main sequence
  initial begin
    mismatches = 0;
    total_checks = 0;
    reset_n = 1'h0;
    {mode_switch_valid, reset_scope_select, programmed_mode} = 3'h0;
    {param_ext_writable, line_fault_pin, hw_reset_terminal} = 3'h0;
    {local_keypad_reset, local_keypad_err_reset} = 2'h0;
    term_run_req = 1'h1;
    mode_switch = ncmg_pkg::NCMG_MODE_EXTERNAL;
    link_startup_mode_select = 8'h00;
    drive_status = 8'hA4;
    drive_monitor = {16'h1234, 16'h0567, 16'h0890, 16'h00AB};
    for (int i = 0; i < 16; i++) special_items[i] = 16'hC000 + 16'(i * 17);
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    t_monitor();
    t_gate();
    t_err();
    t_full();
    t_fault();
    t_local();
    t_write();
    conclude();
  end
endmodule
`default_nettype wire
